//--- common/bridge_perr_defs.svh
// Constants for the bridge write parity error handler.
`ifndef BRIDGE_PERR_DEFS_SVH
`define BRIDGE_PERR_DEFS_SVH

// Bus indices; a direction is numbered after the bus that initiates it.
`define BUS_PRI 0
`define BUS_SEC 1

// Cycles from the data transfer to the parity error output.
`define PERR_LAG_CYCLES 2

// Posted write flag store depth and master time-out length in clocks.
`define PW_DEPTH_DEF 8
`define MTO_CYCLES_DEF 32768

// Bus status bit positions.
`define ST_DET 0
`define ST_DPD 1

// System error cause bit positions.
`define CAUSE_DN_PW 0
`define CAUSE_UP_PW 1
`define CAUSE_MTO 2

// Reset values.
`define STATUS_RST 2'h0
`define CAUSE_RST 3'h0

`endif

//--- common/bridge_perr_pkg.sv
// Types shared by the bridge write parity error handler.
package bridge_perr_pkg;

  typedef enum logic [1:0] {
    DW_IDLE,
    DW_WAIT,
    DW_READY
  } dw_state_type;

endpackage

//--- rtl/bridge_perr_pipe.sv
// Delays a parity error request and drives the parity error pin for it.
`include "bridge_perr_defs.svh"

module bridge_perr_pipe #(
  parameter int unsigned LAG = `PERR_LAG_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic fire_i,
  output logic      perr_n_o,
  output logic      perr_oe_o
);
  import bridge_perr_pkg::*;

  logic [LAG-2:0] sh_q;
  logic           perr_n_q;
  logic           oe_q;

  // The pin is driven high for one cycle after the low cycle so it is left deasserted.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh_q     <= '0;
      perr_n_q <= 1'b1;
      oe_q     <= 1'b0;
    end else begin
      sh_q[0] <= fire_i;
      for (int i = 1; i < LAG - 1; i++) begin
        sh_q[i] <= sh_q[i-1];
      end
      perr_n_q <= ~sh_q[LAG-2];
      oe_q     <= sh_q[LAG-2] | ~perr_n_q;
    end
  end

  assign perr_n_o  = perr_n_q;
  assign perr_oe_o = oe_q;
endmodule

//--- rtl/bridge_flag_mem.sv
// Small flag store for posted write entries with a registered read port.
`include "bridge_perr_defs.svh"

module bridge_flag_mem #(
  parameter int unsigned W     = 1,
  parameter int unsigned DEPTH = `PW_DEPTH_DEF
) (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [W-1:0]             wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [W-1:0]             rdata_o
);
  import bridge_perr_pkg::*;

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] rdata_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rdata_q <= '0;
    end else begin
      if (we_i) begin
        mem_q[waddr_i] <= wdata_i;
      end
      rdata_q <= mem_q[raddr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule

//--- rtl/bridge_write_parity_error_handler.sv
// Write data parity error handling for a transparent two-bus bridge.
`include "bridge_perr_defs.svh"

module bridge_write_parity_error_handler #(
  parameter int unsigned PW_DEPTH   = `PW_DEPTH_DEF,
  parameter int unsigned MTO_CYCLES = `MTO_CYCLES_DEF
) (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        pri_perr_resp_i,
  input  wire logic                        sec_perr_resp_i,
  input  wire logic                        serr_en_i,
  input  wire logic                        pw_perr_serr_dis_i,
  input  wire logic                        mto_serr_en_i,
  input  wire logic                        pri_dw_valid_i,
  input  wire logic                        pri_pw_valid_i,
  input  wire logic                        pri_multi_i,
  input  wire logic [31:0]                 pri_addr_i,
  input  wire logic [3:0]                  pri_cmd_i,
  input  wire logic [31:0]                 pri_ad_i,
  input  wire logic [3:0]                  pri_be_i,
  input  wire logic                        pri_par_i,
  input  wire logic [$clog2(PW_DEPTH)-1:0] pri_pw_wr_idx_i,
  input  wire logic                        sec_dw_valid_i,
  input  wire logic                        sec_pw_valid_i,
  input  wire logic                        sec_multi_i,
  input  wire logic [31:0]                 sec_addr_i,
  input  wire logic [3:0]                  sec_cmd_i,
  input  wire logic [31:0]                 sec_ad_i,
  input  wire logic [3:0]                  sec_be_i,
  input  wire logic                        sec_par_i,
  input  wire logic [$clog2(PW_DEPTH)-1:0] sec_pw_wr_idx_i,
  input  wire logic                        pri_parity_err_n_i,
  input  wire logic                        sec_parity_err_n_i,
  input  wire logic                        dn_tgt_watch_i,
  input  wire logic                        dn_dw_done_i,
  input  wire logic                        dn_pw_done_i,
  input  wire logic [$clog2(PW_DEPTH)-1:0] dn_pw_rd_idx_i,
  input  wire logic                        up_tgt_watch_i,
  input  wire logic                        up_dw_done_i,
  input  wire logic                        up_pw_done_i,
  input  wire logic [$clog2(PW_DEPTH)-1:0] up_pw_rd_idx_i,
  input  wire logic [1:0]                  pri_status_clr_i,
  input  wire logic [1:0]                  sec_status_clr_i,
  input  wire logic                        sig_serr_clr_i,
  input  wire logic [2:0]                  serr_cause_clr_i,
  output logic                             pri_target_ready_n_o,
  output logic                             pri_stop_n_o,
  output logic                             pri_parity_err_n_o,
  output logic                             pri_parity_err_oe_o,
  output logic                             sec_target_ready_n_o,
  output logic                             sec_stop_n_o,
  output logic                             sec_parity_err_n_o,
  output logic                             sec_parity_err_oe_o,
  output logic                             pri_system_err_n_o,
  output logic                             pri_system_err_oe_o,
  output logic                             dn_dw_pending_o,
  output logic                             dn_dw_bad_par_o,
  output logic                             dn_pw_bad_par_o,
  output logic                             up_dw_pending_o,
  output logic                             up_dw_bad_par_o,
  output logic                             up_pw_bad_par_o,
  output logic [1:0]                       pri_status_o,
  output logic [1:0]                       sec_status_o,
  output logic                             sig_serr_o,
  output logic [2:0]                       serr_cause_o
);
  import bridge_perr_pkg::*;

  localparam int unsigned IW = $clog2(PW_DEPTH);
  localparam int unsigned CW = $clog2(MTO_CYCLES + 1);

  // Even parity over data, byte enables and the parity bit; a one means bad parity.
  function automatic logic par_bad(input logic [31:0] d, input logic [3:0] b, input logic p);
    return ^{d, b, p};
  endfunction

  // Status bits: hardware set wins over a clear in the same cycle.
  function automatic logic [1:0] sticky2(input logic [1:0] q, input logic [1:0] set, input logic [1:0] clr);
    return (q & ~clr) | set;
  endfunction

  // Arrays indexed by bus; direction d is initiated on bus d and delivered on the other bus.
  wire [1:0]    dw_v     = {sec_dw_valid_i, pri_dw_valid_i};
  wire [1:0]    pw_v     = {sec_pw_valid_i, pri_pw_valid_i};
  wire [1:0]    multi    = {sec_multi_i, pri_multi_i};
  wire [1:0]    par      = {sec_par_i, pri_par_i};
  wire [1:0]    resp     = {sec_perr_resp_i, pri_perr_resp_i};
  wire [1:0]    perr_pin = {sec_parity_err_n_i, pri_parity_err_n_i};
  wire [1:0]    watch    = {up_tgt_watch_i, dn_tgt_watch_i};
  wire [1:0]    dwdone   = {up_dw_done_i, dn_dw_done_i};
  wire [1:0]    pwdone   = {up_pw_done_i, dn_pw_done_i};
  wire [31:0]   addr [2];
  wire [31:0]   ad [2];
  wire [3:0]    cmd [2];
  wire [3:0]    be [2];
  wire [IW-1:0] wr_idx [2];
  wire [IW-1:0] rd_idx [2];

  assign addr[0]   = pri_addr_i;
  assign addr[1]   = sec_addr_i;
  assign ad[0]     = pri_ad_i;
  assign ad[1]     = sec_ad_i;
  assign cmd[0]    = pri_cmd_i;
  assign cmd[1]    = sec_cmd_i;
  assign be[0]     = pri_be_i;
  assign be[1]     = sec_be_i;
  assign wr_idx[0] = pri_pw_wr_idx_i;
  assign wr_idx[1] = sec_pw_wr_idx_i;
  assign rd_idx[0] = dn_pw_rd_idx_i;
  assign rd_idx[1] = up_pw_rd_idx_i;

  wire [1:0] xfer;
  wire [1:0] disc;
  wire [1:0] retry;
  wire [1:0] perr_fire;
  wire [1:0] det_set;
  wire [1:0] dpd_dir;
  wire [1:0] serr_pw;
  wire [1:0] mto_hit;
  wire [1:0] pend;
  wire [1:0] dw_bad;
  wire [1:0] pw_bad;

  for (genvar d = 0; d < 2; d++) begin : g_dir
    localparam int T = 1 - d;

    dw_state_type state_q;
    dw_state_type state_d;
    logic [31:0]  e_addr_q;
    logic [31:0]  e_data_q;
    logic [3:0]   e_cmd_q;
    logic [3:0]   e_be_q;
    logic         e_bad_q;
    logic         st_perr_q;
    logic         seen_q;
    logic         pend_q;
    logic         pwbad_q;
    logic [CW-1:0] mto_q;
    logic         flag_rd;

    wire bad       = par_bad(ad[d], be[d], par[d]);
    wire same      = (addr[d] == e_addr_q) && (cmd[d] == e_cmd_q) && (ad[d] == e_data_q) && (be[d] == e_be_q);
    wire hit       = dw_v[d] && (state_q == DW_READY) && same;
    wire first     = dw_v[d] && (state_q == DW_IDLE);
    wire reject    = first && bad && resp[d];
    wire queue     = first && !reject;
    wire reatt_bad = hit && bad;
    wire complete  = hit && !bad;
    wire fwd_perr  = complete && st_perr_q && resp[0] && resp[1];
    wire seen_now  = seen_q || (watch[d] && !perr_pin[T]);
    wire expire    = (state_q == DW_READY) && !complete && (mto_q == CW'(MTO_CYCLES - 1));

    assign xfer[d]      = reject || reatt_bad || complete || pw_v[d];
    assign disc[d]      = reject && multi[d];
    assign retry[d]     = dw_v[d] && !(reject || reatt_bad || complete);
    assign perr_fire[d] = ((reject || reatt_bad || (pw_v[d] && bad)) && resp[d]) || fwd_perr;
    assign det_set[d]   = (dw_v[d] || pw_v[d]) && bad;
    assign dpd_dir[d]   = (dwdone[d] || pwdone[d]) && seen_now && resp[T];
    // A flagged entry already carried bad parity from the initiator, so the target's report is expected.
    assign serr_pw[d]   = pwdone[d] && seen_now && !flag_rd && resp[0] && resp[1] && serr_en_i &&
                          ((d != 0) || !pw_perr_serr_dis_i);
    assign mto_hit[d]   = expire;
    assign pend[d]      = pend_q;
    assign dw_bad[d]    = e_bad_q;
    assign pw_bad[d]    = pwbad_q;

    always_comb begin
      state_d = state_q;
      case (state_q)
        DW_IDLE:  if (queue) state_d = DW_WAIT;
        DW_WAIT:  if (dwdone[d]) state_d = DW_READY;
        DW_READY: if (complete || expire) state_d = DW_IDLE;
        default:  state_d = DW_IDLE;
      endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        state_q   <= DW_IDLE;
        e_addr_q  <= '0;
        e_data_q  <= '0;
        e_cmd_q   <= '0;
        e_be_q    <= '0;
        e_bad_q   <= 1'b0;
        st_perr_q <= 1'b0;
        seen_q    <= 1'b0;
        pend_q    <= 1'b0;
        pwbad_q   <= 1'b0;
        mto_q     <= '0;
      end else begin
        state_q <= state_d;
        pend_q  <= (state_d != DW_IDLE);
        pwbad_q <= flag_rd;
        seen_q  <= seen_now && !dwdone[d] && !pwdone[d];
        mto_q   <= (state_d == DW_READY && state_q == DW_READY) ? mto_q + 1'b1 : '0;
        if (queue) begin
          e_addr_q <= addr[d];
          e_data_q <= ad[d];
          e_cmd_q  <= cmd[d];
          e_be_q   <= be[d];
          e_bad_q  <= bad;
        end
        if (state_q == DW_WAIT && dwdone[d]) begin
          st_perr_q <= seen_now;
        end
      end
    end

    bridge_flag_mem #(
      .W     (1),
      .DEPTH (PW_DEPTH)
    ) u_flag (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .we_i      (pw_v[d]),
      .waddr_i   (wr_idx[d]),
      .wdata_i   (bad),
      .raddr_i   (rd_idx[d]),
      .rdata_o   (flag_rd)
    );
  end

  logic [1:0] trdy_n_q;
  logic [1:0] stop_n_q;
  logic [1:0] perr_req_q;
  logic [1:0] pri_st_q;
  logic [1:0] sec_st_q;
  logic       serr_n_q;
  logic       serr_oe_q;
  logic       sig_serr_q;
  logic [2:0] cause_q;

  wire       mto_serr = (|mto_hit) && mto_serr_en_i && serr_en_i;
  wire       serr_any = (|serr_pw) || mto_serr;
  wire [1:0] pri_set  = {dpd_dir[1], det_set[0]};
  wire [1:0] sec_set  = {dpd_dir[0], det_set[1]};
  wire [2:0] cause_set = {mto_serr, serr_pw[1], serr_pw[0]};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trdy_n_q   <= 2'h3;
      stop_n_q   <= 2'h3;
      perr_req_q <= 2'h0;
      pri_st_q   <= `STATUS_RST;
      sec_st_q   <= `STATUS_RST;
      serr_n_q   <= 1'b1;
      serr_oe_q  <= 1'b0;
      sig_serr_q <= 1'b0;
      cause_q    <= `CAUSE_RST;
    end else begin
      trdy_n_q   <= ~xfer;
      stop_n_q   <= ~(retry | disc);
      perr_req_q <= perr_fire;
      pri_st_q   <= sticky2(pri_st_q, pri_set, pri_status_clr_i);
      sec_st_q   <= sticky2(sec_st_q, sec_set, sec_status_clr_i);
      serr_n_q   <= ~serr_any;
      serr_oe_q  <= serr_any;
      sig_serr_q <= (sig_serr_q && !sig_serr_clr_i) || serr_any;
      cause_q    <= (cause_q & ~serr_cause_clr_i) | cause_set;
    end
  end

  bridge_perr_pipe u_pri_perr (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .fire_i    (perr_req_q[`BUS_PRI]),
    .perr_n_o  (pri_parity_err_n_o),
    .perr_oe_o (pri_parity_err_oe_o)
  );

  bridge_perr_pipe u_sec_perr (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .fire_i    (perr_req_q[`BUS_SEC]),
    .perr_n_o  (sec_parity_err_n_o),
    .perr_oe_o (sec_parity_err_oe_o)
  );

  assign pri_target_ready_n_o = trdy_n_q[`BUS_PRI];
  assign pri_stop_n_o         = stop_n_q[`BUS_PRI];
  assign sec_target_ready_n_o = trdy_n_q[`BUS_SEC];
  assign sec_stop_n_o         = stop_n_q[`BUS_SEC];
  assign pri_system_err_n_o   = serr_n_q;
  assign pri_system_err_oe_o  = serr_oe_q;
  assign dn_dw_pending_o      = pend[0];
  assign dn_dw_bad_par_o      = dw_bad[0];
  assign dn_pw_bad_par_o      = pw_bad[0];
  assign up_dw_pending_o      = pend[1];
  assign up_dw_bad_par_o      = dw_bad[1];
  assign up_pw_bad_par_o      = pw_bad[1];
  assign pri_status_o         = pri_st_q;
  assign sec_status_o         = sec_st_q;
  assign sig_serr_o           = sig_serr_q;
  assign serr_cause_o         = cause_q;
endmodule

//--- bench/bridge_perr_monitor.sv
// Concurrent checks bound to the write parity error handler ports.
`include "bridge_perr_defs.svh"

module bridge_perr_monitor (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        pri_perr_resp_i,
  input wire logic        sec_perr_resp_i,
  input wire logic        pri_dw_valid_i,
  input wire logic        pri_pw_valid_i,
  input wire logic        pri_multi_i,
  input wire logic [31:0] pri_ad_i,
  input wire logic [3:0]  pri_be_i,
  input wire logic        pri_par_i,
  input wire logic        sec_parity_err_n_i,
  input wire logic        dn_dw_done_i,
  input wire logic        dn_pw_done_i,
  input wire logic        pri_target_ready_n_o,
  input wire logic        pri_stop_n_o,
  input wire logic        pri_parity_err_n_o,
  input wire logic        pri_parity_err_oe_o,
  input wire logic        pri_system_err_n_o,
  input wire logic        pri_system_err_oe_o,
  input wire logic        dn_dw_pending_o,
  input wire logic        dn_pw_bad_par_o,
  input wire logic [1:0]  pri_status_o,
  input wire logic [1:0]  sec_status_o,
  input wire logic        sig_serr_o,
  input wire logic [2:0]  serr_cause_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic pri_bad = ^{pri_ad_i, pri_be_i, pri_par_i};
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_retry_queue;
    pri_dw_valid_i && !pri_bad && !dn_dw_pending_o |=> !pri_stop_n_o && pri_target_ready_n_o && dn_dw_pending_o;
  endproperty
  a_retry_queue: assert property (p_retry_queue) else $error("good delayed write not queued");
  property p_bad_take;
    pri_dw_valid_i && pri_bad && pri_perr_resp_i && !dn_dw_pending_o |=> !pri_target_ready_n_o
      && pri_stop_n_o != $past(pri_multi_i) ##2 !pri_parity_err_n_o && pri_parity_err_oe_o;
  endproperty
  a_bad_take: assert property (p_bad_take) else $error("bad initial write not taken");
  property p_noresp_queue;
    pri_dw_valid_i && pri_bad && !pri_perr_resp_i && !dn_dw_pending_o |=> !pri_stop_n_o && dn_dw_pending_o
      ##2 pri_parity_err_n_o;
  endproperty
  a_noresp_queue: assert property (p_noresp_queue) else $error("bad write without response not queued");
  property p_det;
    pri_dw_valid_i && pri_bad |=> pri_status_o[`ST_DET];
  endproperty
  a_det: assert property (p_det) else $error("detected parity bit not set");
  property p_pw_perr;
    pri_pw_valid_i && pri_bad && pri_perr_resp_i |-> ##3 !pri_parity_err_n_o
      ##1 pri_parity_err_oe_o && pri_parity_err_n_o;
  endproperty
  a_pw_perr: assert property (p_pw_perr) else $error("posted parity error pin late");
  property p_dpd;
    dn_dw_done_i && !sec_parity_err_n_i && sec_perr_resp_i |=> sec_status_o[`ST_DPD];
  endproperty
  a_dpd: assert property (p_dpd) else $error("secondary data parity bit not set");
  property p_no_fwd_serr;
    dn_pw_done_i && dn_pw_bad_par_o |=> pri_system_err_n_o;
  endproperty
  a_no_fwd_serr: assert property (p_no_fwd_serr) else $error("system error for forwarded parity");
  property p_serr_record;
    !pri_system_err_n_o |-> pri_system_err_oe_o && sig_serr_o && serr_cause_o != 3'h0;
  endproperty
  a_serr_record: assert property (p_serr_record) else $error("system error not recorded");
  c_bad_take: cover property (pri_dw_valid_i && pri_bad && pri_perr_resp_i);
  c_serr: cover property (!pri_system_err_n_o);
  c_dpd: cover property (dn_dw_done_i && !sec_parity_err_n_i);
endmodule

bind bridge_write_parity_error_handler bridge_perr_monitor bridge_perr_monitor_inst (.*);

//--- bench/bridge_far_target.sv
// Far-side target that reports bad write data on its bus parity error pin.
module bridge_far_target (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic bad_data_i,
  output logic      perr_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] lag_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) lag_q <= 2'h0;
    else lag_q <= {lag_q[0], bad_data_i};
  end
  // A target reports two cycles after the transfer; released, the pulled-up pin reads high.
  assign perr_n_o = ~lag_q[1];
endmodule

//--- bench/bridge_write_parity_error_handler_test.sv
// Self-checking bench for the bridge write parity error handler.
`include "bridge_perr_defs.svh"

module bridge_write_parity_error_handler_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MTO = 16;
  typedef struct packed {logic b; logic bad; logic resp; logic perr; logic det;} row_type;
  localparam row_type ROWS [6] = '{5'h06, 5'h0d, 5'h0b, 5'h16, 5'h1d, 5'h1b};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] resp = '0, dwv = '0, pwv = '0, mul = '0, par = '0, watch = '0, dwd = '0, pwd = '0, fbad = '0;
  logic serr_en = 1'b0, dis = 1'b0, mto_en = 1'b0, sig_clr = 1'b0;
  logic [2:0] cclr = '0;
  logic [31:0] addr = 32'h0000_8000;
  logic [31:0] ad [2] = '{32'h0, 32'h0};
  logic [2:0] widx [2] = '{3'h0, 3'h0};
  logic [2:0] ridx [2] = '{3'h0, 3'h0};
  logic [1:0] sclr [2] = '{2'h0, 2'h0};
  wire logic [1:0] trdy_n, stop_n, perr_n, oe, pend, dbad, pwbad, far_n, pin;
  wire logic [1:0] st [2];
  wire logic serr_n, serr_oe, sig;
  wire logic [2:0] cause;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #20 clk_i = ~clk_i;
  // Parity error pins are pulled up, so either party may pull them low.
  assign pin[0] = (oe[0] ? perr_n[0] : 1'b1) & far_n[1];
  assign pin[1] = (oe[1] ? perr_n[1] : 1'b1) & far_n[0];
  bridge_far_target bridge_far_target_inst [1:0] (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bad_data_i(fbad),
    .perr_n_o(far_n));
  bridge_write_parity_error_handler #(.PW_DEPTH(8), .MTO_CYCLES(MTO)) bridge_write_parity_error_handler_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pri_perr_resp_i(resp[0]), .sec_perr_resp_i(resp[1]),
    .serr_en_i(serr_en), .pw_perr_serr_dis_i(dis), .mto_serr_en_i(mto_en), .pri_dw_valid_i(dwv[0]),
    .pri_pw_valid_i(pwv[0]), .pri_multi_i(mul[0]), .pri_addr_i(addr), .pri_cmd_i(4'h7), .pri_ad_i(ad[0]),
    .pri_be_i(4'hf), .pri_par_i(par[0]), .pri_pw_wr_idx_i(widx[0]), .sec_dw_valid_i(dwv[1]),
    .sec_pw_valid_i(pwv[1]), .sec_multi_i(mul[1]), .sec_addr_i(addr), .sec_cmd_i(4'h7), .sec_ad_i(ad[1]),
    .sec_be_i(4'hf), .sec_par_i(par[1]), .sec_pw_wr_idx_i(widx[1]), .pri_parity_err_n_i(pin[0]),
    .sec_parity_err_n_i(pin[1]), .dn_tgt_watch_i(watch[0]), .dn_dw_done_i(dwd[0]), .dn_pw_done_i(pwd[0]),
    .dn_pw_rd_idx_i(ridx[0]), .up_tgt_watch_i(watch[1]), .up_dw_done_i(dwd[1]), .up_pw_done_i(pwd[1]),
    .up_pw_rd_idx_i(ridx[1]), .pri_status_clr_i(sclr[0]), .sec_status_clr_i(sclr[1]), .sig_serr_clr_i(sig_clr),
    .serr_cause_clr_i(cclr), .pri_target_ready_n_o(trdy_n[0]), .pri_stop_n_o(stop_n[0]),
    .pri_parity_err_n_o(perr_n[0]), .pri_parity_err_oe_o(oe[0]), .sec_target_ready_n_o(trdy_n[1]),
    .sec_stop_n_o(stop_n[1]), .sec_parity_err_n_o(perr_n[1]), .sec_parity_err_oe_o(oe[1]),
    .pri_system_err_n_o(serr_n), .pri_system_err_oe_o(serr_oe), .dn_dw_pending_o(pend[0]),
    .dn_dw_bad_par_o(dbad[0]), .dn_pw_bad_par_o(pwbad[0]), .up_dw_pending_o(pend[1]), .up_dw_bad_par_o(dbad[1]),
    .up_pw_bad_par_o(pwbad[1]), .pri_status_o(st[0]), .sec_status_o(st[1]), .sig_serr_o(sig),
    .serr_cause_o(cause));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One data phase; exp holds the ready, stop and parity error pin levels.
  task automatic xfer(input int b, input bit pw, input logic [31:0] d, input bit bad, input bit mu,
                      input logic [2:0] exp);
    ad[b] = d;
    par[b] = ^{d, 4'hf} ^ bad;
    mul[b] = mu;
    if (pw) pwv[b] = 1'b1;
    else dwv[b] = 1'b1;
    step();
    pwv[b] = 1'b0;
    dwv[b] = 1'b0;
    chk({trdy_n[b], stop_n[b]}, exp[2:1]);
    step();
    step();
    chk(perr_n[b], exp[0]);
  endtask
  task automatic deliver(input int d, input bit pw, input bit err);
    watch[d] = 1'b1;
    fbad[d] = err;
    step();
    fbad[d] = 1'b0;
    step();
    if (pw) pwd[d] = 1'b1;
    else dwd[d] = 1'b1;
    step();
    pwd[d] = 1'b0;
    dwd[d] = 1'b0;
    watch[d] = 1'b0;
  endtask
  task automatic clear();
    sclr = '{2'h3, 2'h3};
    sig_clr = 1'b1;
    cclr = 3'h7;
    step();
    sclr = '{2'h0, 2'h0};
    sig_clr = 1'b0;
    cclr = 3'h0;
  endtask
  // The whole sequence needs about 110 cycles; the ceiling leaves wide margin.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    chk({trdy_n, stop_n, perr_n, oe}, 8'hfc);
    chk({serr_n, serr_oe, pend, cause}, 8'h40);
    chk({st[0], st[1], sig}, 8'h00);
    #1 sys_rst_i = 1'b0;
    // The first request waits for the second edge after release.
    step();
    foreach (ROWS[i]) begin
      resp = {2{ROWS[i].resp}};
      widx[ROWS[i].b] = 3'(i);
      xfer(ROWS[i].b, 1'b1, 32'h5a00_0000 + i, ROWS[i].bad, 1'b0, {2'b01, ROWS[i].perr});
      chk(st[ROWS[i].b][`ST_DET], ROWS[i].det);
      clear();
    end
    serr_en = 1'b1;
    mto_en = 1'b1;
    resp = 2'b11;
    xfer(0, 1'b0, 32'hc0de_0001, 1'b1, 1'b1, 3'b000);
    chk(pend[0], 1'b0);
    resp = 2'b10;
    xfer(0, 1'b0, 32'hc0de_0002, 1'b1, 1'b0, 3'b101);
    chk({pend[0], dbad[0], st[0][`ST_DET]}, 3'b111);
    resp = 2'b11;
    deliver(0, 1'b0, 1'b1);
    chk(st[1][`ST_DPD], 1'b1);
    xfer(0, 1'b0, 32'hc0de_0002, 1'b1, 1'b0, 3'b010);
    chk(pend[0], 1'b1);
    xfer(0, 1'b0, 32'hc0de_00ff, 1'b0, 1'b0, 3'b101);
    chk({pend[0], dbad[0]}, 2'b11);
    xfer(0, 1'b0, 32'hc0de_0002, 1'b0, 1'b0, 3'b010);
    chk(pend[0], 1'b0);
    xfer(0, 1'b0, 32'hc0de_0003, 1'b0, 1'b0, 3'b101);
    deliver(0, 1'b0, 1'b0);
    repeat (MTO + 4) step();
    chk({pend[0], sig, cause[`CAUSE_MTO]}, 3'b011);
    clear();
    xfer(1, 1'b0, 32'hbeef_0003, 1'b1, 1'b1, 3'b000);
    chk({pend[1], st[1][`ST_DET]}, 2'b01);
    xfer(1, 1'b0, 32'hbeef_0004, 1'b0, 1'b0, 3'b101);
    chk({pend[1], dbad[1]}, 2'b10);
    deliver(1, 1'b0, 1'b1);
    chk(st[0][`ST_DPD], 1'b1);
    clear();
    xfer(1, 1'b0, 32'hbeef_0004, 1'b1, 1'b0, 3'b010);
    chk({pend[1], st[1][`ST_DET]}, 2'b11);
    xfer(1, 1'b0, 32'hbeef_0004, 1'b0, 1'b0, 3'b010);
    chk(pend[1], 1'b0);
    clear();
    ridx[0] = 3'h0;
    deliver(0, 1'b1, 1'b1);
    chk({serr_n, serr_oe, cause[`CAUSE_DN_PW]}, 3'b011);
    clear();
    ridx[0] = 3'h1;
    deliver(0, 1'b1, 1'b1);
    chk({serr_n, pwbad[0], sig}, 3'b110);
    ridx[0] = 3'h0;
    dis = 1'b1;
    deliver(0, 1'b1, 1'b1);
    chk({serr_n, sig}, 2'b10);
    ridx[1] = 3'h3;
    deliver(1, 1'b1, 1'b1);
    chk({serr_n, pwbad[1], cause[`CAUSE_UP_PW]}, 3'b001);
    // A reset in mid-run must drop the held entry and every sticky bit at once.
    xfer(0, 1'b0, 32'hc0de_0005, 1'b0, 1'b0, 3'b101);
    sys_rst_i = 1'b1;
    #1;
    chk({pend, st[0], st[1], sig}, 8'h00);
    chk({cause, trdy_n, stop_n}, 8'h0f);
    step();
    sys_rst_i = 1'b0;
    step();
    xfer(0, 1'b0, 32'hc0de_0005, 1'b0, 1'b0, 3'b101);
    chk(pend[0], 1'b1);
    give_verdict();
  end
endmodule
